// ===== core/dsps_consts.svh
// constants for the dual-slot power switch control block
// assumes inclusion by the package and the core module only
`ifndef DSPS_CONSTS_SVH
`define DSPS_CONSTS_SVH
`define DSPS_WORD_W 11
`define DSPS_BIT_PA0 0
`define DSPS_BIT_PA1 1
`define DSPS_BIT_LA_LO 2
`define DSPS_BIT_LA_HI 3
`define DSPS_BIT_PB0 4
`define DSPS_BIT_PB1 5
`define DSPS_BIT_LB_HI 6
`define DSPS_BIT_LB_LO 7
`define DSPS_BIT_ON 8
`define DSPS_BIT_SELA 9
`define DSPS_BIT_SELB 10
`define DSPS_WORD_RST 11'h000
`define DSPS_SEL_RST 3'h0
`define DSPS_SYNC_LO 2'h0
`define DSPS_SYNC_HI 2'h3
`define DSPS_FAULT_RST 4'h0
`define DSPS_FLAG_RST 1'h1
`define DSPS_BIT_RST 1'h0
`endif

// ===== core/dsps_pkg.sv
// types for the dual-slot power switch control block
// assumes dsps_consts.svh is on the include path
`include "dsps_consts.svh"
package dsps_pkg;
  // output setting of one supply pin
  typedef enum logic [2:0] {
    DSPS_OUT_GND = 3'h0,
    DSPS_OUT_3V3 = 3'h1,
    DSPS_OUT_5V = 3'h2,
    DSPS_OUT_12V = 3'h3,
    DSPS_OUT_HIZ = 3'h4
  } dsps_out_t;

  typedef struct packed {
    logic [1:0] clk_sync;
    logic [1:0] dat_sync;
    logic [1:0] lat_sync;
    logic [1:0] rsth_sync;
    logic [1:0] rstl_sync;
    logic clk_prev;
    logic lat_prev;
    logic [`DSPS_WORD_W-1:0] shift;
    logic [`DSPS_WORD_W-1:0] word;
    logic word_valid;
    logic mode_meta;
    logic mode_ind;
    logic [3:0] fault_meta;
    logic [3:0] fault_sync;
    dsps_out_t a_logic;
    dsps_out_t b_logic;
    dsps_out_t a_prog;
    dsps_out_t b_prog;
    logic flag_n;
  } dsps_state_t;
endpackage : dsps_pkg

// ===== core/dsps_core.sv
// serial control logic of a dual-slot card power switch
// assumes serial link, resets, mode and fault inputs are asynchronous pins
// Overview of operation
// - in reset every supply output is grounded, nothing else switched
// - after reset outputs stay grounded until a new word is latched
// - latch strobes during reset are ignored; a pin reset keeps the latched word
// - active-high or active-low reset input each enters grounded state
// - power-up (rst_b) enters the grounded state without pin resets
// - data is shifted in on each rising serial clock edge
// - rising latch edge moves the 11-bit shifted word to the control word
// - fault flag is low while any output has overcurrent or overtemp
// - independent mode: program out 00 gnd,10 12V,11 hiz,01 3.3/5 by bit9/10
// - compatibility mode: program out 01 follows slot logic output
// - bit 8 low forces every supply output to high impedance
// - mode high selects independent, low selects compatibility decoding
`timescale 1ns/1ns
`include "dsps_consts.svh"
module dsps_core
  import dsps_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // serial link pins
  input wire logic serial_data,
  input wire logic serial_clock,
  input wire logic serial_latch,
  // reset pins
  input wire logic reset_pin,
  input wire logic reset_pin_n,
  // configuration and status pins
  input wire logic mode_independent,
  input wire logic [3:0] fault_detect,
  // supply switch settings
  output dsps_out_t slot_a_logic_supply_out,
  output dsps_out_t slot_b_logic_supply_out,
  output dsps_out_t slot_a_program_supply_out,
  output dsps_out_t slot_b_program_supply_out,
  output logic overcurrent_flag_n
);

  // registered state and its next value
  dsps_state_t s_q;
  dsps_state_t s_d;

  // synchronised pin levels, read only from the second stage
  logic clk_lvl;
  logic dat_lvl;
  logic lat_lvl;
  logic rsth_lvl;
  logic rstl_lvl;

  // events and conditions of the current cycle
  logic in_reset;
  logic clk_rise;
  logic lat_rise;
  logic fault_any;
  logic [`DSPS_WORD_W-1:0] shift_next;

  // candidate settings decoded from the shift register
  dsps_out_t la;
  dsps_out_t lb;
  dsps_out_t pa;
  dsps_out_t pb;

  // logic supply decode of one slot; code 11 grounds like 00
  function automatic dsps_out_t logic_dec(input logic hi, input logic lo);
    case ({hi, lo})
      2'b00: logic_dec = DSPS_OUT_GND;
      2'b01: logic_dec = DSPS_OUT_3V3;
      2'b10: logic_dec = DSPS_OUT_5V;
      2'b11: logic_dec = DSPS_OUT_GND;
      default: logic_dec = DSPS_OUT_GND;
    endcase
  endfunction : logic_dec

  // program supply decode of one slot
  function automatic dsps_out_t prog_dec(input logic b0, input logic b1, input logic sel,
                                         input logic indep, input dsps_out_t lsup);
    case ({b0, b1})
      2'b00: prog_dec = DSPS_OUT_GND;
      2'b10: prog_dec = DSPS_OUT_12V;
      2'b11: prog_dec = DSPS_OUT_HIZ;
      2'b01: begin
        if (indep) begin
          prog_dec = sel ? DSPS_OUT_5V : DSPS_OUT_3V3;
        end else begin
          prog_dec = lsup;
        end
      end
      default: prog_dec = DSPS_OUT_GND;
    endcase
  endfunction : prog_dec

  // one step of a two-stage synchroniser
  function automatic logic [1:0] sync2(input logic [1:0] stages, input logic pin);
    sync2 = {stages[0], pin};
  endfunction : sync2

  // rising edge from the current and the remembered level
  function automatic logic rose(input logic now_lvl, input logic last_lvl);
    rose = now_lvl & ~last_lvl;
  endfunction : rose

  always_comb begin
    s_d = s_q;

    // first stages are the only readers of the pins
    s_d.clk_sync = sync2(s_q.clk_sync, serial_clock);
    s_d.dat_sync = sync2(s_q.dat_sync, serial_data);
    s_d.lat_sync = sync2(s_q.lat_sync, serial_latch);
    s_d.rsth_sync = sync2(s_q.rsth_sync, reset_pin);
    s_d.rstl_sync = sync2(s_q.rstl_sync, reset_pin_n);
    s_d.mode_meta = mode_independent;
    s_d.mode_ind = s_q.mode_meta;
    s_d.fault_meta = fault_detect;
    s_d.fault_sync = s_q.fault_meta;

    // second stages feed all the logic below
    clk_lvl = s_q.clk_sync[1];
    dat_lvl = s_q.dat_sync[1];
    lat_lvl = s_q.lat_sync[1];
    rsth_lvl = s_q.rsth_sync[1];
    rstl_lvl = s_q.rstl_sync[1];

    // edge detectors remember the level of the previous cycle
    s_d.clk_prev = clk_lvl;
    s_d.lat_prev = lat_lvl;
    clk_rise = rose(clk_lvl, s_q.clk_prev);
    lat_rise = rose(lat_lvl, s_q.lat_prev);
    in_reset = rsth_lvl | ~rstl_lvl;

    // flag follows the synchronised faults, nothing is latched
    fault_any = |s_q.fault_sync;
    s_d.flag_n = ~fault_any;

    // shift right: the first bit sent ends at bit 0 after eleven clocks
    shift_next = {dat_lvl, s_q.shift[`DSPS_WORD_W-1:1]};
    if (clk_rise) begin
      s_d.shift = shift_next;
    end

    // decode the candidate word every cycle; only a latch takes it
    la = logic_dec(s_q.shift[`DSPS_BIT_LA_HI], s_q.shift[`DSPS_BIT_LA_LO]);
    lb = logic_dec(s_q.shift[`DSPS_BIT_LB_HI], s_q.shift[`DSPS_BIT_LB_LO]);
    pa = prog_dec(s_q.shift[`DSPS_BIT_PA0], s_q.shift[`DSPS_BIT_PA1],
                  s_q.shift[`DSPS_BIT_SELA], s_q.mode_ind, la);
    pb = prog_dec(s_q.shift[`DSPS_BIT_PB0], s_q.shift[`DSPS_BIT_PB1],
                  s_q.shift[`DSPS_BIT_SELB], s_q.mode_ind, lb);

    if (in_reset) begin
      // strobes during a pin reset are dropped, not held over
      s_d.word_valid = 1'b0;
      s_d.a_logic = DSPS_OUT_GND;
      s_d.b_logic = DSPS_OUT_GND;
      s_d.a_prog = DSPS_OUT_GND;
      s_d.b_prog = DSPS_OUT_GND;
    end else if (lat_rise) begin
      s_d.word = s_q.shift;
      s_d.word_valid = 1'b1;
      if (!s_q.shift[`DSPS_BIT_ON]) begin
        s_d.a_logic = DSPS_OUT_HIZ;
        s_d.b_logic = DSPS_OUT_HIZ;
        s_d.a_prog = DSPS_OUT_HIZ;
        s_d.b_prog = DSPS_OUT_HIZ;
      end else begin
        s_d.a_logic = la;
        s_d.b_logic = lb;
        s_d.a_prog = pa;
        s_d.b_prog = pb;
      end
    end else begin
      // no event: settings stand, so a mode change alone moves nothing
      s_d.word = s_q.word;
      s_d.word_valid = s_q.word_valid;
      s_d.a_logic = s_q.a_logic;
      s_d.b_logic = s_q.b_logic;
      s_d.a_prog = s_q.a_prog;
      s_d.b_prog = s_q.b_prog;
    end
  end

  // clk_en low freezes every stage, synchronisers included
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      // power-up: idle pin copies, so no false edge or pin reset follows
      s_q.clk_sync <= `DSPS_SYNC_LO;
      s_q.dat_sync <= `DSPS_SYNC_LO;
      s_q.lat_sync <= `DSPS_SYNC_LO;
      s_q.rsth_sync <= `DSPS_SYNC_LO;
      s_q.rstl_sync <= `DSPS_SYNC_HI;
      s_q.clk_prev <= `DSPS_BIT_RST;
      s_q.lat_prev <= `DSPS_BIT_RST;
      s_q.mode_meta <= `DSPS_BIT_RST;
      s_q.mode_ind <= `DSPS_BIT_RST;
      s_q.fault_meta <= `DSPS_FAULT_RST;
      s_q.fault_sync <= `DSPS_FAULT_RST;
      s_q.flag_n <= `DSPS_FLAG_RST;
      // word and grounded outputs
      s_q.shift <= `DSPS_WORD_RST;
      s_q.word <= `DSPS_WORD_RST;
      s_q.word_valid <= `DSPS_BIT_RST;
      s_q.a_logic <= DSPS_OUT_GND;
      s_q.b_logic <= DSPS_OUT_GND;
      s_q.a_prog <= DSPS_OUT_GND;
      s_q.b_prog <= DSPS_OUT_GND;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // every output straight from its register
  assign slot_a_logic_supply_out = s_q.a_logic;
  assign slot_b_logic_supply_out = s_q.b_logic;
  assign slot_a_program_supply_out = s_q.a_prog;
  assign slot_b_program_supply_out = s_q.b_prog;
  assign overcurrent_flag_n = s_q.flag_n;

endmodule : dsps_core

// ===== bench/dsps_host.sv
// host model: one word LSB first, then a latch strobe
// assumes calls start 1 ns after a clk edge
`timescale 1ns/1ns
module dsps_host (output logic serial_data = 1'h0, serial_clock = 1'h0, serial_latch = 1'h0);
  task automatic send(input logic [10:0] w);
    for (int i = 0; i < 11; i++) begin
      serial_data = w[i];
      #40 serial_clock = 1'h1;
      #40 serial_clock = 1'h0;
    end
    serial_data = ~serial_data; // released line must not repeat the last bit
    #40 serial_latch = 1'h1;
    #40 serial_latch = 1'h0;
  endtask : send
endmodule : dsps_host

// ===== bench/dsps_monitor.sv
// assertions on dsps_core outputs
// assumes the bind below
`timescale 1ns/1ns
module dsps_monitor import dsps_pkg::*; (
  // pins
  input wire logic clk, rst_b, serial_latch, reset_pin, reset_pin_n,
  input wire logic [3:0] fault_detect,
  // results
  input wire dsps_out_t slot_a_logic_supply_out, slot_b_logic_supply_out,
  input wire dsps_out_t slot_a_program_supply_out, slot_b_program_supply_out,
  input wire logic overcurrent_flag_n);
  wire [11:0] outs = {slot_a_logic_supply_out, slot_b_logic_supply_out,
    slot_a_program_supply_out, slot_b_program_supply_out};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  rst_gnd_a: assert property (disable iff (1'h0) !rst_b |=> outs == 12'h000)
    else $error("reset");
  pin_hi_a: assert property (reset_pin [*5] |-> outs == 12'h000)
    else $error("pin");
  pin_lo_a: assert property (!reset_pin_n [*5] |-> outs == 12'h000)
    else $error("pin n");
  flag_set_a: assert property ((|fault_detect) [*4] |-> !overcurrent_flag_n)
    else $error("flag");
  flag_clr_a: assert property ((fault_detect == 4'h0) [*4] |-> overcurrent_flag_n)
    else $error("flag stuck");
  hold_a: assert property ((!serial_latch && !reset_pin && reset_pin_n) [*6] |-> $stable(outs))
    else $error("hold");
  hiz_all_a: assert property (slot_a_logic_supply_out == DSPS_OUT_HIZ |->
    outs == {4{DSPS_OUT_HIZ}}) else $error("hiz");
  no_twelve_a: assert property (slot_b_logic_supply_out != DSPS_OUT_12V)
    else $error("12 V");
endmodule : dsps_monitor
bind dsps_core dsps_monitor dsps_monitor_inst (.*);

// ===== bench/dsps_core_tb.sv
// random words through the host model, results from a queue
// assumes dsps_host on the link and dsps_monitor bound
`timescale 1ns/1ns
module dsps_core_tb import dsps_pkg::*; ;
  logic clk = 1'h0, rst_b = 1'h0, reset_pin = 1'h0, reset_pin_n = 1'h1, mode_independent = 1'h0;
  logic serial_data, serial_clock, serial_latch, overcurrent_flag_n;
  logic [3:0] fault_detect = 4'h0;
  dsps_out_t slot_a_logic_supply_out, slot_b_logic_supply_out;
  dsps_out_t slot_a_program_supply_out, slot_b_program_supply_out;
  logic [31:0] s = 32'hC616;
  logic [12:0] q[$];
  int failures = 0, checks_done = 0;
  event ev;
  initial forever #2 clk = ~clk;
  dsps_host dsps_host_inst (.*);
  dsps_core dsps_core_inst (.*, .clk_en(1'h1));
  function automatic dsps_out_t lg(logic [1:0] c);
    return c == 2'h1 ? DSPS_OUT_3V3 : c == 2'h2 ? DSPS_OUT_5V : DSPS_OUT_GND;
  endfunction : lg
  function automatic dsps_out_t pg(logic [1:0] c, logic m, v, dsps_out_t l);
    if (c == 2'h1) return m ? (v ? DSPS_OUT_5V : DSPS_OUT_3V3) : l;
    return c == 2'h0 ? DSPS_OUT_GND : c == 2'h2 ? DSPS_OUT_12V : DSPS_OUT_HIZ;
  endfunction : pg
  function automatic logic [11:0] dec(logic [10:0] w, logic m);
    if (!w[8]) return {4{DSPS_OUT_HIZ}};
    return {lg({w[3], w[2]}), lg({w[6], w[7]}), pg({w[0], w[1]}, m, w[9], lg({w[3], w[2]})),
      pg({w[4], w[5]}, m, w[10], lg({w[6], w[7]}))};
  endfunction : dec
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  task note(input logic [11:0] o);
    q.push_back({o, ~|fault_detect});
    -> ev;
    repeat (9) @(posedge clk);
    #1;
  endtask : note
  task cmp(input logic [12:0] g, e);
    checks_done++;
    if (g !== e) failures++;
    if (g !== e) $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
  endtask : cmp
  task complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  initial forever begin
    @ev;
    repeat (8) @(posedge clk);
    cmp({slot_a_logic_supply_out, slot_b_logic_supply_out, slot_a_program_supply_out,
      slot_b_program_supply_out, overcurrent_flag_n}, q.pop_front());
  end
  initial begin
    #100000 failures++; // whole run needs about 30 us
    complete_run;
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_b = 1'h1;
    note(12'h000);
    for (int i = 0; i < 28; i++) begin
      s = xs(s);
      {mode_independent, fault_detect} = s[15:11];
      {reset_pin, reset_pin_n} = {i == 26, i != 27};
      dsps_host_inst.send(s[10:0]);
      note(i > 25 ? 12'h000 : dec(s[10:0], mode_independent));
      {reset_pin, reset_pin_n} = 2'h1;
      if (i > 25) note(12'h000);
    end
    complete_run;
  end
endmodule : dsps_core_tb
